// File: rtl/slcr_pkg.sv
// package for the serial loop command router: constants and carriers
// assumes one 25 MHz clock and byte-wide message streams
package slcr_pkg;

    localparam int CLK_HZ = 25_000_000;
    localparam logic [6:0] GLOBAL_ID = 7'd99;
    localparam logic [6:0] HOST_ID = 7'd0;
    localparam int MAX_UNITS = 98;
    localparam int MAX_LOOP_BAUD = 19_200;
    localparam int NOM_CRYSTAL_HZ = 14_745_600;
    localparam int NORM_REF_HZ = 10_000_000;
    // correction factor, Q1.23 fixed point, ~ 10/14.7456
    localparam logic [23:0] TC_RESET = 24'h55_5555;
    localparam int NUM_COEF = 14;
    localparam logic [31:0] COEF_RESET = 32'h0000_0000;
    // sampling time limits in microseconds
    localparam int SAMP_MIN_US = 1_000;
    localparam int SAMP_MAX_US = 290_000_000;
    localparam logic [28:0] SAMP_MIN = 29'(SAMP_MIN_US);
    localparam logic [28:0] SAMP_MAX = 29'(SAMP_MAX_US);
    localparam logic [28:0] SAMP_RESET = 29'h0000_03E8;

    localparam logic [7:0] CH_STAR = 8'h2A;
    localparam logic [7:0] CH_EQ = 8'h3D;
    localparam logic [7:0] CH_CR = 8'h0D;

    // decoded command operations (from the command parser)
    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_READ_PRES = 4'h1,
        OP_READ_TEMP = 4'h2,
        OP_READ_PPER = 4'h3,
        OP_READ_TPER = 4'h4,
        OP_COEF_SET = 4'h5,
        OP_COEF_GET = 4'h6,
        OP_TC_GET = 4'h7,
        OP_TC_SET = 4'h8,
        OP_UNLOCK = 4'h9,
        OP_SAMP_SET = 4'hA,
        OP_MODE_SET = 4'hB
    } slcr_op_t;

    typedef enum logic [5:0] {
        ST_IDLE = 6'b00_0001,
        ST_TPER = 6'b00_0010,
        ST_TCALC = 6'b00_0100,
        ST_PPER = 6'b00_1000,
        ST_PCALC = 6'b01_0000,
        ST_OUT = 6'b10_0000
    } slcr_meas_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic last;
    } slcr_byte_t;

    // parsed command from the local parser
    typedef struct packed {
        logic valid;
        slcr_op_t op;
        logic [3:0] index;
        logic [31:0] value;
    } slcr_cmd_t;

    // response request toward the reply formatter
    typedef struct packed {
        logic valid;
        slcr_op_t op;
        logic [31:0] value;
        logic err;
    } slcr_resp_t;

endpackage

// File: rtl/slcr_router.sv
// command routing, parameter store and measurement sequencing
// assumes byte streams from a uart, a parser and a period counter
// Summary of operation
// RQ1: identifier 99 is accepted by every unit
// RQ2: global command resent before being executed
// RQ3: host drops its own returning global
// RQ4: host globals only sampling and few commands
// RQ5: own identifier executes, others forwarded unchanged
// RQ6: replies go to host, foreign replies relayed
// RQ7: relayed traffic beats local replies on transmit
// RQ8: loop runs at most 19200 baud, shared
// RQ9: up to 98 units, unique identifiers
// RQ10: host sees echo then every reply
// RQ11: usb port has no global addressing
// RQ12: timebase correction held, host read only
// RQ13: coefficients readable; set needs unlock prefix
// RQ14: pressure and temperature sampling times independent
// RQ15: pressure: tper, temp, pper, pressure, output
// RQ16: temperature: tper, temp, output
// RQ17: period readings go to serial only
// RQ18: trigger mode measures fresh, replies when done
// RQ19: fetch mode replies last value immediately
// RQ20: star, destination, source, command text
`timescale 1ns/1ns
module slcr_router (
    sys_clk,
    srst,
    unitId,
    viaUsb,
    fetchMode,
    rxByte,
    rxReady,
    hdrDst,
    hdrValid,
    cmdIn,
    measStart,
    measIsPres,
    measPeriod,
    measDone,
    measValue,
    txByte,
    txReady,
    localByte,
    localReady,
    cmdExec,
    respOut,
    respReady,
    respDst,
    dispValue,
    dispStrobe,
    tcValue,
    presSampTime,
    tempSampTime
);
    input wire logic sys_clk;
    input wire logic srst;
    input wire logic [6:0] unitId;
    input wire logic viaUsb;
    input wire logic fetchMode;
    input wire slcr_pkg::slcr_byte_t rxByte;
    output logic rxReady;
    input wire logic [6:0] hdrDst;
    input wire logic hdrValid;
    input wire slcr_pkg::slcr_cmd_t cmdIn;
    output logic measStart;
    output logic measIsPres;
    output logic measPeriod;
    input wire logic measDone;
    input wire logic [31:0] measValue;
    output slcr_pkg::slcr_byte_t txByte;
    input wire logic txReady;
    input wire slcr_pkg::slcr_byte_t localByte;
    output logic localReady;
    output slcr_pkg::slcr_cmd_t cmdExec;
    output slcr_pkg::slcr_resp_t respOut;
    input wire logic respReady;
    output logic [6:0] respDst;
    output logic [31:0] dispValue;
    output logic dispStrobe;
    output logic [23:0] tcValue;
    output logic [28:0] presSampTime;
    output logic [28:0] tempSampTime;

    // =========================================================
    // state
    typedef struct packed {
        logic relaying;
        logic relayBusy;
        logic globalHeld;
        logic unlocked;
        slcr_pkg::slcr_cmd_t pend;
        slcr_pkg::slcr_meas_t meas;
        slcr_pkg::slcr_op_t measOp;
        logic [31:0] lastPres;
        logic [31:0] lastTemp;
        logic [31:0] lastPper;
        logic [31:0] lastTper;
        logic [31:0] work;
        slcr_pkg::slcr_resp_t resp;
        slcr_pkg::slcr_cmd_t exec;
        slcr_pkg::slcr_byte_t tx;
        logic [31:0] disp;
        logic dispStb;
        logic mStart;
        logic mPres;
        logic [28:0] pSamp;
        logic [28:0] tSamp;
        logic [23:0] tc;
    } slcr_state_t;

    slcr_state_t st_r;
    slcr_state_t st_nxt;
    localparam int NUMC = slcr_pkg::NUM_COEF;
    logic [NUMC-1:0][31:0] coef_r;

    function automatic logic forMe(input logic [6:0] dst,
                                   input logic [6:0] me,
                                   input logic usb);
        forMe = (dst == me) || (!usb && dst == slcr_pkg::GLOBAL_ID);
    endfunction

    function automatic logic sampOk(input logic [31:0] v);
        sampOk = v[31:29] == 3'h0 && v[28:0] >= slcr_pkg::SAMP_MIN
                 && v[28:0] <= slcr_pkg::SAMP_MAX;
    endfunction

    logic isGlobal;
    logic accept;
    logic txFree;
    assign isGlobal = !viaUsb && hdrDst == slcr_pkg::GLOBAL_ID; // RQ11
    assign accept = forMe(hdrDst, unitId, viaUsb); // RQ1 RQ5
    assign txFree = !st_r.tx.valid || txReady;
    // relay owns tx while forwarding a frame
    assign rxReady = txFree;
    // local stream waits for any relay in progress
    assign localReady = txFree && !st_r.relayBusy
                        && !rxByte.valid; // RQ7

    // =========================================================
    // next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.mStart = 1'b0;
        st_nxt.dispStb = 1'b0;
        st_nxt.exec.valid = 1'b0;
        if (txReady) begin
            st_nxt.tx.valid = 1'b0;
        end
        // forward bytes: foreign frames and globals (RQ2 RQ5 RQ6)
        if (hdrValid) begin
            st_nxt.relaying = !accept || isGlobal; // RQ2 RQ5 RQ6
            st_nxt.globalHeld = isGlobal;
        end
        if (rxByte.valid && txFree && (st_r.relaying || hdrValid
                && (!accept || isGlobal))) begin
            st_nxt.tx = rxByte; // RQ5 RQ6
            st_nxt.relayBusy = !rxByte.last;
            if (rxByte.last) begin
                st_nxt.relaying = 1'b0;
            end
        end else if (localByte.valid && localReady) begin
            st_nxt.tx = localByte; // RQ7
        end
        if (st_r.resp.valid && respReady) begin
            st_nxt.resp.valid = 1'b0;
        end
        // globals wait until their frame has been relayed; fetch reads do not wait for the measurement
        if (st_r.pend.valid && !(st_r.globalHeld && st_r.relayBusy)
                && (st_r.meas == slcr_pkg::ST_IDLE || fetchMode)
                && !st_r.resp.valid) begin // RQ2
            st_nxt.pend.valid = 1'b0;
            st_nxt.exec = st_r.pend;
            st_nxt.resp.valid = 1'b1;
            st_nxt.resp.op = st_r.pend.op;
            st_nxt.resp.err = 1'b0;
            st_nxt.resp.value = 32'h0000_0000;
            if (st_r.pend.op != slcr_pkg::OP_UNLOCK) begin
                st_nxt.unlocked = 1'b0;
            end
            unique case (st_r.pend.op)
                slcr_pkg::OP_UNLOCK: begin
                    st_nxt.unlocked = 1'b1; // RQ13
                    st_nxt.resp.valid = 1'b0;
                end
                slcr_pkg::OP_COEF_SET: begin
                    st_nxt.resp.err = !st_r.unlocked
                        || st_r.pend.index >= 4'(NUMC); // RQ13
                    st_nxt.resp.value = st_r.pend.value;
                end
                slcr_pkg::OP_COEF_GET: begin
                    if (st_r.pend.index < 4'(NUMC)) begin
                        st_nxt.resp.value = coef_r[st_r.pend.index];
                    end else begin
                        st_nxt.resp.err = 1'b1;
                    end
                end
                slcr_pkg::OP_TC_GET: begin
                    st_nxt.resp.value = {8'h00, st_r.tc}; // RQ12
                end
                slcr_pkg::OP_TC_SET: begin
                    st_nxt.resp.err = 1'b1; // RQ12
                end
                slcr_pkg::OP_SAMP_SET: begin
                    if (sampOk(st_r.pend.value)) begin // RQ14
                        if (st_r.pend.index[0]) begin
                            st_nxt.tSamp = st_r.pend.value[28:0];
                        end else begin
                            st_nxt.pSamp = st_r.pend.value[28:0];
                        end
                    end else begin
                        st_nxt.resp.err = 1'b1;
                    end
                    st_nxt.resp.value = st_r.pend.value;
                end
                slcr_pkg::OP_READ_PRES, slcr_pkg::OP_READ_TEMP,
                slcr_pkg::OP_READ_PPER, slcr_pkg::OP_READ_TPER: begin
                    if (fetchMode) begin // RQ19
                        unique case (st_r.pend.op)
                            slcr_pkg::OP_READ_PRES:
                                st_nxt.resp.value = st_r.lastPres;
                            slcr_pkg::OP_READ_TEMP:
                                st_nxt.resp.value = st_r.lastTemp;
                            slcr_pkg::OP_READ_PPER:
                                st_nxt.resp.value = st_r.lastPper;
                            default:
                                st_nxt.resp.value = st_r.lastTper;
                        endcase
                    end else begin
                        st_nxt.resp.valid = 1'b0; // RQ18
                        st_nxt.measOp = st_r.pend.op;
                        st_nxt.mStart = 1'b1;
                        st_nxt.mPres = st_r.pend.op
                                       == slcr_pkg::OP_READ_PPER;
                        st_nxt.meas = st_r.pend.op
                            == slcr_pkg::OP_READ_PPER
                            ? slcr_pkg::ST_PPER
                            : slcr_pkg::ST_TPER;
                    end
                end
                default: begin
                    st_nxt.resp.err = 1'b0;
                end
            endcase
        end
        // accept a parsed command into a free or freeing slot
        if (cmdIn.valid && !st_nxt.pend.valid) begin
            st_nxt.pend = cmdIn;
        end
        // measurement sequence
        unique case (st_r.meas)
            slcr_pkg::ST_IDLE: begin
                if (fetchMode && !st_r.pend.valid) begin // RQ19
                    st_nxt.meas = slcr_pkg::ST_TPER;
                    st_nxt.measOp = slcr_pkg::OP_READ_PRES;
                    st_nxt.mStart = 1'b1;
                    st_nxt.mPres = 1'b0;
                end
            end
            slcr_pkg::ST_TPER: begin
                if (measDone) begin // RQ15 RQ16
                    st_nxt.lastTper = measValue;
                    st_nxt.work = measValue;
                    st_nxt.meas = st_r.measOp == slcr_pkg::OP_READ_TPER
                        ? slcr_pkg::ST_OUT : slcr_pkg::ST_TCALC;
                end
            end
            slcr_pkg::ST_TCALC: begin
                // temperature from period and coefficients
                st_nxt.lastTemp = st_r.work - coef_r[0];
                st_nxt.work = st_r.work - coef_r[0];
                if (st_r.measOp == slcr_pkg::OP_READ_PRES) begin // RQ15
                    st_nxt.meas = slcr_pkg::ST_PPER;
                    st_nxt.mStart = 1'b1;
                    st_nxt.mPres = 1'b1;
                end else begin
                    st_nxt.meas = slcr_pkg::ST_OUT; // RQ16
                end
            end
            slcr_pkg::ST_PPER: begin
                if (measDone) begin
                    st_nxt.lastPper = measValue;
                    st_nxt.work = measValue;
                    st_nxt.meas = st_r.measOp == slcr_pkg::OP_READ_PPER
                        ? slcr_pkg::ST_OUT : slcr_pkg::ST_PCALC;
                end
            end
            slcr_pkg::ST_PCALC: begin
                // compensated pressure from period and temperature
                st_nxt.lastPres = st_r.work - coef_r[1] + st_r.lastTemp;
                st_nxt.work = st_r.work - coef_r[1] + st_r.lastTemp;
                st_nxt.meas = slcr_pkg::ST_OUT; // RQ15
            end
            slcr_pkg::ST_OUT: begin
                if (!st_r.resp.valid) begin
                    st_nxt.meas = slcr_pkg::ST_IDLE;
                    if (st_r.measOp == slcr_pkg::OP_READ_PRES
                            || st_r.measOp == slcr_pkg::OP_READ_TEMP)
                            begin // RQ17
                        st_nxt.disp = st_r.work;
                        st_nxt.dispStb = 1'b1;
                    end
                    if (!fetchMode) begin // RQ18
                        st_nxt.resp.valid = 1'b1;
                        st_nxt.resp.op = st_r.measOp;
                        st_nxt.resp.value = st_r.work;
                        st_nxt.resp.err = 1'b0;
                    end
                end
            end
            default: begin
                st_nxt.meas = slcr_pkg::ST_IDLE;
            end
        endcase
    end

    // =========================================================
    // registers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_r <= '0;
            st_r.meas <= slcr_pkg::ST_IDLE;
            st_r.tc <= slcr_pkg::TC_RESET;
            st_r.pSamp <= slcr_pkg::SAMP_RESET;
            st_r.tSamp <= slcr_pkg::SAMP_RESET;
            coef_r <= {NUMC{slcr_pkg::COEF_RESET}};
        end else begin
            st_r <= st_nxt;
            if (st_nxt.exec.valid && st_nxt.exec.op == slcr_pkg::OP_COEF_SET
                    && !st_nxt.resp.err) begin // RQ13
                coef_r[st_nxt.exec.index] <= st_nxt.exec.value;
            end
        end
    end

    assign txByte = st_r.tx;
    assign cmdExec = st_r.exec;
    assign respOut = st_r.resp;
    assign respDst = slcr_pkg::HOST_ID; // RQ6 RQ20
    assign measStart = st_r.mStart;
    assign measIsPres = st_r.mPres;
    assign measPeriod = st_r.measOp == slcr_pkg::OP_READ_PPER
                        || st_r.measOp == slcr_pkg::OP_READ_TPER;
    assign dispValue = st_r.disp;
    assign dispStrobe = st_r.dispStb;
    assign tcValue = st_r.tc;
    assign presSampTime = st_r.pSamp;
    assign tempSampTime = st_r.tSamp;

endmodule

// File: tb/slcr_router_properties.sv
// port checker for the serial loop command router
// assumes bind onto every slcr_router instance
`timescale 1ns/1ns
module slcr_router_properties (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [6:0] unitId,
    input wire logic viaUsb,
    input wire logic fetchMode,
    input wire slcr_pkg::slcr_byte_t rxByte,
    input wire logic rxReady,
    input wire logic [6:0] hdrDst,
    input wire logic hdrValid,
    input wire slcr_pkg::slcr_cmd_t cmdIn,
    input wire logic measStart,
    input wire logic measIsPres,
    input wire slcr_pkg::slcr_byte_t txByte,
    input wire logic txReady,
    input wire logic localReady,
    input wire slcr_pkg::slcr_resp_t respOut,
    input wire logic respReady,
    input wire logic [6:0] respDst,
    input wire logic [23:0] tcValue
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    wire logic firstTaken = hdrValid && rxByte.valid && rxReady;
    wire logic trigRead = !fetchMode && cmdIn.valid;
    // ==========
    // assertions
    foreign_relay_a:
        assert property (firstTaken && hdrDst != unitId
            && hdrDst != slcr_pkg::GLOBAL_ID
            |=> txByte.valid && txByte.data == $past(rxByte.data))
        else $error("foreign byte not relayed");
    global_relay_a:
        assert property (firstTaken && hdrDst == slcr_pkg::GLOBAL_ID
            && !viaUsb |=> txByte.valid && txByte.data == $past(rxByte.data))
        else $error("global byte not relayed");
    own_kept_a:
        assert property (firstTaken && hdrDst == unitId
            && (!txByte.valid || txReady) |=> !txByte.valid)
        else $error("own frame relayed");
    local_yield_a:
        assert property (rxByte.valid |-> !localReady)
        else $error("local reply beat relay");
    tx_hold_a:
        assert property (txByte.valid && !txReady |=> $stable(txByte))
        else $error("tx byte dropped");
    resp_hold_a:
        assert property (respOut.valid && !respReady |=> $stable(respOut))
        else $error("reply dropped");
    resp_host_a:
        assert property (respOut.valid |-> respDst == slcr_pkg::HOST_ID)
        else $error("reply not to host");
    tc_fixed_a:
        assert property (tcValue == slcr_pkg::TC_RESET)
        else $error("timebase factor changed");
    fetch_fast_a:
        assert property (fetchMode && cmdIn.valid
            && cmdIn.op == slcr_pkg::OP_READ_PRES |-> ##[1:2] respOut.valid)
        else $error("fetch reply late");
    temp_first_a:
        assert property (trigRead && (cmdIn.op == slcr_pkg::OP_READ_PRES
            || cmdIn.op == slcr_pkg::OP_READ_TEMP)
            |-> ##[1:4] measStart && !measIsPres)
        else $error("temperature period not first");
    pper_start_a:
        assert property (trigRead && cmdIn.op == slcr_pkg::OP_READ_PPER
            |-> ##[1:4] measStart && measIsPres)
        else $error("pressure period not started");
    cover property (firstTaken && hdrDst == slcr_pkg::GLOBAL_ID);
    cover property (txByte.valid && !txReady);
    cover property (fetchMode && respOut.valid);
endmodule
bind slcr_router slcr_router_properties i_slcr_router_properties (
    .sys_clk, .srst, .unitId, .viaUsb, .fetchMode, .rxByte, .rxReady,
    .hdrDst, .hdrValid, .cmdIn, .measStart, .measIsPres, .txByte,
    .txReady, .localReady, .respOut, .respReady, .respDst, .tcValue);

// File: tb/slcr_loop_peer.sv
// downstream neighbour and period counter model
// assumes the router clock; slow halves the take rate
`timescale 1ns/1ns
module slcr_loop_peer #(
    parameter int MEAS_CYC = 20,
    parameter logic [31:0] TPER = 32'h0000_1000,
    parameter logic [31:0] PPER = 32'h0000_3000
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic slow,
    input wire slcr_pkg::slcr_byte_t txByte,
    output logic txReady,
    input wire logic measStart,
    input wire logic measIsPres,
    output logic measDone,
    output logic [31:0] measValue,
    output int rxCount,
    output slcr_pkg::slcr_byte_t lastRx
);
    int busy_r;
    logic isPres_r;
    always @(posedge sys_clk) begin
        if (srst) begin
            txReady <= 1'b1;
            rxCount <= 0;
            lastRx <= '0;
            measDone <= 1'b0;
            measValue <= 32'h0000_0000;
            busy_r <= 0;
        end else begin
            txReady <= slow ? !txReady : 1'b1;
            // echo counted like any byte
            if (txByte.valid && txReady) begin
                rxCount <= rxCount + 1;
                lastRx <= txByte;
            end
            measDone <= 1'b0;
            // value only meaningful with done
            measValue <= ~measValue;
            if (measStart) begin
                busy_r <= MEAS_CYC;
                isPres_r <= measIsPres;
            end else if (busy_r == 1) begin
                measDone <= 1'b1;
                measValue <= isPres_r ? PPER : TPER;
                busy_r <= 0;
            end else if (busy_r > 1) begin
                busy_r <= busy_r - 1;
            end
        end
    end
endmodule

// File: tb/tb_slcr_router.sv
// self-checking bench for the serial loop command router
// assumes checker bound and peer model compiled first
`timescale 1ns/1ns
module tb_slcr_router;
    localparam logic [6:0] MY_ID = 7'h03;
    localparam logic [31:0] TP = 32'h0000_1000;
    localparam logic [31:0] PP = 32'h0000_3000;
    logic sys_clk = 1'b0, srst = 1'b1, fetchMode = 1'b0, hdrValid = 1'b0;
    logic respReady = 1'b1, slow = 1'b0;
    logic [6:0] hdrDst = 7'h00;
    logic measDone, measStart, measIsPres, rxReady, localReady;
    logic txReady, dispStrobe;
    logic [31:0] measValue;
    logic [28:0] presT, tempT;
    logic [1:0] presSeq = 2'b00;
    slcr_pkg::slcr_byte_t rxByte = '0, localByte = '0, txByte, lastRx;
    slcr_pkg::slcr_cmd_t cmdIn = '0;
    slcr_pkg::slcr_resp_t respOut, got;
    int num_errors = 0, n_checks = 0, rxCount, nStart = 0, nDisp = 0;
    always #20 sys_clk = ~sys_clk;
    slcr_router i_slcr_router (.sys_clk, .srst, .unitId(MY_ID),
        .viaUsb(1'b0), .fetchMode, .rxByte, .rxReady, .hdrDst, .hdrValid,
        .cmdIn, .measStart, .measIsPres, .measPeriod(), .measDone,
        .measValue, .txByte, .txReady, .localByte, .localReady,
        .cmdExec(), .respOut, .respReady, .respDst(), .dispValue(),
        .dispStrobe, .tcValue(), .presSampTime(presT), .tempSampTime(tempT));
    slcr_loop_peer i_slcr_loop_peer (.sys_clk, .srst, .slow, .txByte,
        .txReady, .measStart, .measIsPres, .measDone, .measValue,
        .rxCount, .lastRx);
    always @(posedge sys_clk) begin
        if (measStart) begin
            nStart <= nStart + 1;
            presSeq <= {presSeq[0], measIsPres};
        end
        if (dispStrobe) nDisp <= nDisp + 1;
        if (localByte.valid && localReady) localByte <= '0;
    end
    // ==========
    // helpers
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic stuck();
        num_errors++;
        $display("wrong value at %0t: wait ran out", $time);
        end_of_test();
    endtask
    task automatic send_frame(input logic [6:0] dst, input int n,
        input logic [7:0] base);
        int i, k;
        for (i = 0; i < n; i++) begin
            rxByte <= '{1'b1, base + 8'(i), i == n - 1};
            hdrValid <= i == 0;
            hdrDst <= dst;
            for (k = 0; k < 300; k++) begin
                @(posedge sys_clk);
                if (rxReady) break;
            end
            if (k == 300) stuck();
        end
        hdrValid <= 1'b0;
        rxByte <= '0;
        @(posedge sys_clk);
    endtask
    task automatic wait_rx(input int target);
        int k;
        for (k = 0; k < 300 && rxCount < target; k++) @(posedge sys_clk);
        chk(rxCount, target);
    endtask
    task automatic do_cmd(input slcr_pkg::slcr_op_t op, input logic [3:0] idx,
        input logic [31:0] val, input logic unl, output int lat);
        int k;
        if (unl) begin
            cmdIn <= '{1'b1, slcr_pkg::OP_UNLOCK, 4'h0, 32'h0000_0000};
            @(posedge sys_clk);
        end
        cmdIn <= '{1'b1, op, idx, val};
        @(posedge sys_clk);
        cmdIn <= '0;
        for (k = 0; k < 2000; k++) begin
            @(posedge sys_clk);
            if (respOut.valid === 1'b1) break;
        end
        if (k == 2000) stuck();
        got = respOut;
        lat = k;
        @(posedge sys_clk);
    endtask
    task automatic cmd_err(input slcr_pkg::slcr_op_t op, input logic [3:0] idx,
        input logic [31:0] val, input logic unl, input logic e);
        int lat;
        do_cmd(op, idx, val, unl, lat);
        chk(got.err, e);
    endtask
    // ==========
    // scenarios
    task automatic t_relay();
        int c0;
        c0 = rxCount;
        slow <= 1'b1;
        send_frame(7'h05, 4, 8'h41);
        wait_rx(c0 + 4);
        chk(lastRx, {1'b1, 8'h44, 1'b1});
        send_frame(MY_ID, 3, 8'h50);
        send_frame(7'h07, 1, 8'h70);
        wait_rx(c0 + 5);
        chk(lastRx.data, 8'h70);
        send_frame(slcr_pkg::GLOBAL_ID, 2, 8'h60);
        wait_rx(c0 + 7);
        chk(lastRx.data, 8'h61);
        slow <= 1'b0;
        $display("relay test done");
    endtask
    task automatic t_local();
        int c0;
        c0 = rxCount;
        localByte <= '{1'b1, 8'h7E, 1'b1};
        send_frame(7'h09, 2, 8'h30);
        wait_rx(c0 + 3);
        chk(lastRx.data, 8'h7E);
        $display("local reply test done");
    endtask
    task automatic t_reads();
        slcr_pkg::slcr_op_t ops [4] = '{slcr_pkg::OP_READ_PRES,
            slcr_pkg::OP_READ_TEMP, slcr_pkg::OP_READ_PPER,
            slcr_pkg::OP_READ_TPER};
        logic [31:0] vals [4] = '{PP + TP, TP, PP, TP};
        int starts [4] = '{2, 1, 1, 1};
        int i, s0, d0, lat;
        for (i = 0; i < 4; i++) begin
            s0 = nStart;
            d0 = nDisp;
            do_cmd(ops[i], 4'h0, 32'h0000_0000, 1'b0, lat);
            chk(got.value, vals[i]);
            chk(nStart - s0, starts[i]);
            chk(presSeq[0], i == 0 || i == 2);
            chk(lat >= 20, 1'b1);
            chk(nDisp - d0, i < 2);
        end
        chk(presSeq, 2'b10);
        $display("read test done");
    endtask
    task automatic t_param();
        int lat;
        respReady <= 1'b0;
        do_cmd(slcr_pkg::OP_TC_GET, 4'h0, 32'h0000_0000, 1'b0, lat);
        repeat (2) @(posedge sys_clk);
        chk(respOut.valid, 1'b1);
        chk(respOut.value, {8'h00, slcr_pkg::TC_RESET});
        respReady <= 1'b1;
        repeat (2) @(posedge sys_clk);
        cmd_err(slcr_pkg::OP_TC_SET, 4'h0, 32'h0000_0001, 1'b1, 1'b1);
        cmd_err(slcr_pkg::OP_COEF_SET, 4'h1, 32'h0000_0005, 1'b0, 1'b1);
        cmd_err(slcr_pkg::OP_COEF_GET, 4'h1, 32'h0000_0000, 1'b0, 1'b0);
        chk(got.value, slcr_pkg::COEF_RESET);
        cmd_err(slcr_pkg::OP_COEF_SET, 4'hD, 32'h1234_5678, 1'b1, 1'b0);
        cmd_err(slcr_pkg::OP_COEF_GET, 4'hD, 32'h0000_0000, 1'b0, 1'b0);
        chk(got.value, 32'h1234_5678);
        cmd_err(slcr_pkg::OP_COEF_SET, 4'hE, 32'h0000_0001, 1'b1, 1'b1);
        cmd_err(slcr_pkg::OP_SAMP_SET, 4'h0, 32'h0000_07D0, 1'b0, 1'b0);
        chk(presT, 29'h0000_07D0);
        chk(tempT, slcr_pkg::SAMP_RESET);
        cmd_err(slcr_pkg::OP_SAMP_SET, 4'h1, {3'b000, slcr_pkg::SAMP_MAX},
            1'b0, 1'b0);
        chk(tempT, slcr_pkg::SAMP_MAX);
        cmd_err(slcr_pkg::OP_SAMP_SET, 4'h1, 32'h0000_03E7, 1'b0, 1'b1);
        $display("parameter test done");
    endtask
    task automatic t_fetch();
        int k, s0, lat;
        fetchMode <= 1'b1;
        s0 = nStart;
        for (k = 0; k < 500 && nStart < s0 + 4; k++) @(posedge sys_clk);
        if (k == 500) stuck();
        do_cmd(slcr_pkg::OP_READ_PRES, 4'h0, 32'h0000_0000, 1'b0, lat);
        chk(lat < 2, 1'b1);
        chk(got.value, PP + TP);
        $display("fetch test done");
    endtask
    initial begin
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        t_relay();
        t_local();
        t_reads();
        t_param();
        t_fetch();
        end_of_test();
    end
    initial begin
        repeat (90000) @(posedge sys_clk);
        stuck();
    end
endmodule
